// ### hdl/fdr_pkg.sv
// Package for the fan duty ramp smoothing block: register map, fields and timing
package fdr_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W          = 8;
	localparam int unsigned DATA_W          = 8;
	localparam int unsigned DUTY_W          = 8;
	localparam logic [7:0]  ADDR_RAMP_CTL_B = 8'h63;
	localparam logic [7:0]  RAMP_CTL_B_RST  = 8'h00;
	localparam logic [7:0]  READ_ZERO       = 8'h00;

	// Field positions of acoustic_ramp_control_b
	localparam int unsigned LOCAL_RATE_LSB   = 0;
	localparam int unsigned LOCAL_ENABLE_BIT = 3;
	localparam int unsigned REM2_RATE_LSB    = 4;
	localparam int unsigned REM2_ENABLE_BIT  = 7;
	localparam int unsigned RATE_W           = 3;

	// Channel indices
	localparam int unsigned NUM_CH   = 2;
	localparam int unsigned CH_LOCAL = 0;
	localparam int unsigned CH_REM2  = 1;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned TENTHS_PER_SEC  = 10;
	localparam int unsigned CYC_PER_TENTH   = CLK_HZ / TENTHS_PER_SEC;
	localparam int unsigned SLOWDOWN_FACTOR = 4;
	localparam int unsigned FULL_SCALE      = 255;
	localparam logic [7:0]  DUTY_MAX        = 8'hff;
	localparam logic [7:0]  DUTY_RST        = 8'h00;

	// Duty increment per time slot, per rate code
	localparam int unsigned RATE_STEP [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
	// Full 0..100% ramp time in tenths of a second, normal and long slot mode
	localparam int unsigned RAMP_TENTHS_NORM [8] = '{375, 188, 125, 75, 47, 31, 16, 8};
	localparam int unsigned RAMP_TENTHS_LONG [8] = '{522, 261, 174, 104, 65, 44, 22, 11};

	localparam int unsigned SLOT_W = 32;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic              enable;
		logic [RATE_W-1:0] rate;
	} fdr_chan_cfg_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} fdr_bus_req_t;

endpackage

// ### hdl/fdr_ramp_smooth.sv
// Fan duty ramp smoothing stage for the local and second remote channels
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module fdr_ramp_smooth
	import fdr_pkg::*;
#(
	parameter int unsigned TENTH_SEC_CYCLES = fdr_pkg::CYC_PER_TENTH
) (
	input  wire logic                         clock_i,
	input  wire logic                         rstn_i,
	input  wire fdr_pkg::fdr_bus_req_t        bus_i,
	output var  logic [fdr_pkg::DATA_W-1:0]   rdata_o,
	input  wire logic                         cfg_lock_i,
	input  wire logic                         long_slot_i,
	input  wire logic [fdr_pkg::NUM_CH-1:0]   slowdown_i,
	input  wire logic [fdr_pkg::DUTY_W-1:0]   local_target_i,
	input  wire logic [fdr_pkg::DUTY_W-1:0]   remote2_target_i,
	output var  logic [fdr_pkg::DUTY_W-1:0]   local_fan_drive_output_o,
	output var  logic [fdr_pkg::DUTY_W-1:0]   remote2_fan_drive_output_o
);
	import fdr_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Duty increment of one slot for a rate code
	function automatic logic [DUTY_W-1:0] rate_step(
		input logic [RATE_W-1:0] code
	);
		rate_step = RATE_STEP[code][DUTY_W-1:0];
	endfunction

	// Full-ramp time in tenths of a second; the long table stretches every code
	function automatic int unsigned ramp_tenths(
		input logic [RATE_W-1:0] code,
		input logic              long_mode
	);
		if (long_mode) begin
			ramp_tenths = RAMP_TENTHS_LONG[code];
		end else begin
			ramp_tenths = RAMP_TENTHS_NORM[code];
		end
	endfunction

	// Slots a full-scale ramp needs; the last slot may carry a partial step
	function automatic int unsigned slots_per_ramp(
		input logic [RATE_W-1:0] code
	);
		int unsigned step;
		step           = 32'(rate_step(code));
		slots_per_ramp = (FULL_SCALE + step - 1) / step;
	endfunction

	// Cycles per time slot: the ramp time spread evenly over its slots.
	// Division rounds down, so a full ramp ends slightly early rather than late.
	function automatic logic [SLOT_W-1:0] slot_len(
		input logic [RATE_W-1:0] code,
		input logic              long_mode,
		input logic              slow
	);
		int unsigned cyc;
		cyc = (ramp_tenths(code, long_mode) * TENTH_SEC_CYCLES) / slots_per_ramp(code);
		if (slow) begin
			cyc = cyc * SLOWDOWN_FACTOR;
		end
		if (cyc == 0) begin
			cyc = 1;
		end
		return cyc[SLOT_W-1:0];
	endfunction

	// One step of at most the code's increment toward the target, either direction;
	// the target itself is taken when it lies closer than a full step
	function automatic logic [DUTY_W-1:0] step_toward(
		input logic [DUTY_W-1:0] cur,
		input logic [DUTY_W-1:0] tgt,
		input logic [RATE_W-1:0] code
	);
		logic [DUTY_W-1:0] inc;
		inc = rate_step(code);
		if (tgt > cur) begin
			step_toward = ((tgt - cur) > inc) ? (cur + inc) : tgt;
		end else begin
			step_toward = ((cur - tgt) > inc) ? (cur - inc) : tgt;
		end
	endfunction

	// Field decode shared by both channels
	function automatic fdr_chan_cfg_t chan_cfg(
		input logic [DATA_W-1:0] ctl,
		input int unsigned       rate_lsb,
		input int unsigned       enable_bit
	);
		chan_cfg.rate   = ctl[rate_lsb +: RATE_W];
		chan_cfg.enable = ctl[enable_bit];
	endfunction

	// Slot boundary; >= so that a rate change mid-slot never strands the timer
	// above a shorter new slot length
	function automatic logic slot_done(
		input logic [SLOT_W-1:0] tick,
		input logic [SLOT_W-1:0] len
	);
		slot_done = (tick >= (len - 32'h1));
	endfunction

	// Slot timer: held at zero while bypassed or settled, so a new target
	// arriving while settled waits one whole slot before its first step
	function automatic logic [SLOT_W-1:0] next_tick(
		input logic              enable,
		input logic              slot_end,
		input logic              settled,
		input logic [SLOT_W-1:0] tick
	);
		if (!enable || slot_end || settled) begin
			next_tick = '0;
		end else begin
			next_tick = tick + 32'h1;
		end
	endfunction

	// Next drive duty: bypass follows the target, smoothing steps only at slot ends
	function automatic logic [DUTY_W-1:0] next_duty(
		input fdr_chan_cfg_t     cfg,
		input logic              slot_end,
		input logic [DUTY_W-1:0] cur,
		input logic [DUTY_W-1:0] tgt
	);
		if (!cfg.enable) begin
			next_duty = tgt;
		end else if (slot_end) begin
			next_duty = step_toward(cur, tgt, cfg.rate);
		end else begin
			next_duty = cur;
		end
	endfunction

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	logic [DATA_W-1:0] ramp_ctl_b_r;
	logic [DATA_W-1:0] rdata_r;
	logic              hit;

	assign hit = (bus_i.addr == ADDR_RAMP_CTL_B);

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			ramp_ctl_b_r <= RAMP_CTL_B_RST;
		end else if (bus_i.wr && hit && !cfg_lock_i) begin
			ramp_ctl_b_r <= bus_i.wdata;
		end
	end

	// Unmapped reads answer zero; data stands only in the cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			rdata_r <= READ_ZERO;
		end else if (bus_i.rd && hit) begin
			rdata_r <= ramp_ctl_b_r;
		end else begin
			rdata_r <= READ_ZERO;
		end
	end

	assign rdata_o = rdata_r;

	// ------------------------------------------------------------------
	// Local channel
	// ------------------------------------------------------------------
	fdr_chan_cfg_t     local_cfg;
	logic [SLOT_W-1:0] local_len;
	logic              local_slot_end;
	logic              local_settled;
	logic [SLOT_W-1:0] local_tick_r;
	logic [SLOT_W-1:0] local_tick_nxt;
	logic [DUTY_W-1:0] local_duty_r;
	logic [DUTY_W-1:0] local_duty_nxt;

	assign local_cfg      = chan_cfg(ramp_ctl_b_r, LOCAL_RATE_LSB, LOCAL_ENABLE_BIT);
	assign local_len      = slot_len(local_cfg.rate, long_slot_i, slowdown_i[CH_LOCAL]);
	assign local_slot_end = slot_done(local_tick_r, local_len);
	assign local_settled  = (local_duty_r == local_target_i);
	assign local_tick_nxt = next_tick(local_cfg.enable, local_slot_end, local_settled, local_tick_r);
	assign local_duty_nxt = next_duty(local_cfg, local_slot_end, local_duty_r, local_target_i);

	// ------------------------------------------------------------------
	// Local slot timer
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			local_tick_r <= '0;
		end else begin
			local_tick_r <= local_tick_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Local smoothed duty
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			local_duty_r <= DUTY_RST;
		end else begin
			local_duty_r <= local_duty_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Second remote channel
	// ------------------------------------------------------------------
	fdr_chan_cfg_t     remote2_cfg;
	logic [SLOT_W-1:0] remote2_len;
	logic              remote2_slot_end;
	logic              remote2_settled;
	logic [SLOT_W-1:0] remote2_tick_r;
	logic [SLOT_W-1:0] remote2_tick_nxt;
	logic [DUTY_W-1:0] remote2_duty_r;
	logic [DUTY_W-1:0] remote2_duty_nxt;

	assign remote2_cfg      = chan_cfg(ramp_ctl_b_r, REM2_RATE_LSB, REM2_ENABLE_BIT);
	assign remote2_len      = slot_len(remote2_cfg.rate, long_slot_i, slowdown_i[CH_REM2]);
	assign remote2_slot_end = slot_done(remote2_tick_r, remote2_len);
	assign remote2_settled  = (remote2_duty_r == remote2_target_i);
	assign remote2_tick_nxt = next_tick(remote2_cfg.enable, remote2_slot_end, remote2_settled, remote2_tick_r);
	assign remote2_duty_nxt = next_duty(remote2_cfg, remote2_slot_end, remote2_duty_r, remote2_target_i);

	// ------------------------------------------------------------------
	// Second remote slot timer
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			remote2_tick_r <= '0;
		end else begin
			remote2_tick_r <= remote2_tick_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Second remote smoothed duty
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			remote2_duty_r <= DUTY_RST;
		end else begin
			remote2_duty_r <= remote2_duty_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Drive outputs, straight from the duty registers
	// ------------------------------------------------------------------
	assign local_fan_drive_output_o   = local_duty_r;
	assign remote2_fan_drive_output_o = remote2_duty_r;

endmodule // fdr_ramp_smooth

`default_nettype wire

// ### verification/fdr_ramp_smooth_assertions.sv
// Port-level assertions for the fan duty ramp smoothing stage
`timescale 1ns/100ps
`default_nettype none
module fdr_ramp_smooth_assertions
	import fdr_pkg::*;
#(parameter int unsigned TENTH_SEC_CYCLES = 10) (
	input wire logic                  clock_i, rstn_i, cfg_lock_i, long_slot_i,
	input wire fdr_pkg::fdr_bus_req_t bus_i,
	input wire logic [1:0]            slowdown_i,
	input wire logic [7:0]            rdata_o, local_target_i, remote2_target_i,
	input wire logic [7:0]            local_fan_drive_output_o, remote2_fan_drive_output_o
);
	// ------------------------------
	// Register mirror and checks
	// ------------------------------
	wire logic [7:0] lo = local_fan_drive_output_o;
	wire logic [7:0] ro = remote2_fan_drive_output_o;
	logic [7:0] ctl_r;
	always_ff @(posedge clock_i) begin
		if (!rstn_i) ctl_r <= RAMP_CTL_B_RST;
		else if (bus_i.wr && bus_i.addr == ADDR_RAMP_CTL_B && !cfg_lock_i) ctl_r <= bus_i.wdata;
	end
	// Toward the target, never past it, at most one step
	function automatic logic near(logic [7:0] o, p, t, logic [2:0] c);
		return ((o >= p && o <= t) || (o <= p && o >= t)) && 32'(o > p ? o - p : p - o) <= RATE_STEP[c];
	endfunction
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	a_reset_clear: assert property (disable iff (1'b0) !rstn_i |=> !(rdata_o | lo | ro))
		else $error("reset did not clear outputs");
	a_read_stands: assert property (!$past(bus_i.rd) |-> rdata_o == READ_ZERO)
		else $error("read data outside its cycle");
	a_read_value: assert property ($past(bus_i.rd) |-> rdata_o == ($past(bus_i.addr) == ADDR_RAMP_CTL_B ? ctl_r : 8'h00))
		else $error("wrong read data");
	a_local_bypass: assert property (!ctl_r[3] |=> lo == $past(local_target_i))
		else $error("local duty not passed through");
	a_rem2_bypass: assert property (!ctl_r[7] |=> ro == $past(remote2_target_i))
		else $error("remote2 duty not passed through");
	a_local_limit: assert property (ctl_r[3] |=> near(lo, $past(lo), $past(local_target_i), $past(ctl_r[2:0])))
		else $error("local duty step out of range");
	a_rem2_limit: assert property (ctl_r[7] |=> near(ro, $past(ro), $past(remote2_target_i), $past(ctl_r[6:4])))
		else $error("remote2 duty step out of range");
	a_local_slot: assert property ($changed(lo) && $past(ctl_r[3]) |=> ($stable(lo) || !$past(ctl_r[3])) [*8])
		else $error("local steps too close together");
endmodule // fdr_ramp_smooth_assertions
bind fdr_ramp_smooth fdr_ramp_smooth_assertions #(.TENTH_SEC_CYCLES(TENTH_SEC_CYCLES)) i_chk (.clock_i, .rstn_i,
	.cfg_lock_i, .long_slot_i, .bus_i, .slowdown_i, .rdata_o, .local_target_i, .remote2_target_i,
	.local_fan_drive_output_o, .remote2_fan_drive_output_o);
`default_nettype wire

// ### verification/fdr_ramp_smooth_bench.sv
// Self-checking bench for the fan duty ramp smoothing stage
`timescale 1ns/100ps
`default_nettype none
module fdr_ramp_smooth_bench;
	import fdr_pkg::*;
	// ------------------------------
	// Harness and bus cycles
	// ------------------------------
	localparam int unsigned TS = 10;
	logic         clock_i = 1'b0, rstn_i = 1'b0, lock = 1'b0, ls = 1'b0;
	logic [1:0]   sd = 2'h0;
	logic [7:0]   lt = 8'h00, rt = 8'h00, rd, lo, ro;
	fdr_bus_req_t bus = '0;
	int           n_errors = 0, comparisons = 0;
	fdr_ramp_smooth #(.TENTH_SEC_CYCLES(TS)) i_dut (.clock_i, .rstn_i, .bus_i(bus), .rdata_o(rd), .cfg_lock_i(lock),
		.long_slot_i(ls), .slowdown_i(sd), .local_target_i(lt), .remote2_target_i(rt),
		.local_fan_drive_output_o(lo), .remote2_fan_drive_output_o(ro));
	initial forever #25 clock_i = ~clock_i;
	task automatic chk(input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("%0d comparisons, %0d mismatches", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// An idle cycle follows each strobe, so back-to-back calls never reassign it in one step
	task automatic op(input logic [7:0] a, input logic w, input logic [7:0] d, exp);
		bus <= '{a, d, w, !w};
		@(posedge clock_i);
		bus <= '0;
		#1 if (!w) chk(rd, exp);
		@(posedge clock_i);
	endtask
	task automatic t_reg();
		op(ADDR_RAMP_CTL_B, 1'b0, 8'h00, RAMP_CTL_B_RST);
		op(8'h62, 1'b1, 8'hff, 8'h00);
		op(8'h62, 1'b0, 8'h00, READ_ZERO);
		op(ADDR_RAMP_CTL_B, 1'b1, 8'ha5, 8'h00);
		op(ADDR_RAMP_CTL_B, 1'b0, 8'h00, 8'ha5);
		lock <= 1'b1;
		op(ADDR_RAMP_CTL_B, 1'b1, 8'h5a, 8'h00);
		op(ADDR_RAMP_CTL_B, 1'b0, 8'h00, 8'ha5);
		lock <= 1'b0;
		$display("register test done");
	endtask
	// Smoothing also limits falls: one step per slot down from full scale
	task automatic t_fall();
		int n;
		ls <= 1'b0;
		sd <= 2'h0;
		op(ADDR_RAMP_CTL_B, 1'b1, 8'h00, 8'h00);
		lt <= DUTY_MAX;
		repeat (2) @(posedge clock_i);
		#1 chk(lo, DUTY_MAX);
		@(posedge clock_i);
		op(ADDR_RAMP_CTL_B, 1'b1, 8'h0f, 8'h00);
		lt <= 8'h00;
		n = 0;
		do begin
			@(posedge clock_i);
			#1 n++;
		end while (lo === DUTY_MAX && n < 300);
		if (n >= 300) begin
			n_errors++;
			end_sim();
		end
		chk(8'(n), 8'(RAMP_TENTHS_NORM[7] * TS / ((FULL_SCALE + RATE_STEP[7] - 1) / RATE_STEP[7])));
		chk(lo, 8'(FULL_SCALE - RATE_STEP[7]));
		@(posedge clock_i);
		$display("fall test done");
	endtask
	// Wait from a new target to the first step is one full slot of the code in use
	task automatic t_ramp(input logic ch, input logic [2:0] c, input logic l, input logic s);
		int n;
		int len;
		len = (l ? RAMP_TENTHS_LONG[c] : RAMP_TENTHS_NORM[c]) * TS / ((FULL_SCALE + RATE_STEP[c] - 1) / RATE_STEP[c]);
		len = (len < 1) ? 1 : len * (s ? 4 : 1);
		op(ADDR_RAMP_CTL_B, 1'b1, 8'h00, 8'h00);
		lt <= 8'h00;
		rt <= 8'h00;
		@(posedge clock_i);
		op(ADDR_RAMP_CTL_B, 1'b1, ch ? {1'b1, c, 4'h0} : {4'h0, 1'b1, c}, 8'h00);
		ls <= l;
		sd <= {ch & s, !ch & s};
		if (ch) rt <= DUTY_MAX;
		else lt <= DUTY_MAX;
		n = 0;
		do begin
			@(posedge clock_i);
			#1 n++;
		end while ((ch ? ro : lo) === 8'h00 && n < 300);
		if (n >= 300) begin
			n_errors++;
			end_sim();
		end
		chk(8'(n), 8'(len));
		chk(ch ? ro : lo, 8'(RATE_STEP[c]));
		@(posedge clock_i);
		$display("ramp test done");
	endtask
	initial begin
		repeat (16) @(posedge clock_i);
		rstn_i <= 1'b1;
		t_reg();
		t_fall();
		for (int c = 0; c < 8; c++) begin
			t_ramp(1'b0, 3'(c), c[0], c[1]);
			t_ramp(1'b1, 3'(c), c[1], c[0]);
		end
		end_sim();
	end
	initial begin
		repeat (100000) @(posedge clock_i);
		n_errors++;
		end_sim();
	end
endmodule // fdr_ramp_smooth_bench
`default_nettype wire
